// ### pfbo_defines.svh
// Offsets, field positions, reset values and timing counts of the flash host.
`ifndef PFBO_DEFINES_SVH
`define PFBO_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PFBO_OFF_CTRL 8'h00
`define PFBO_OFF_ADDR 8'h04
`define PFBO_OFF_WDATA 8'h08
`define PFBO_OFF_RDATA 8'h0c
`define PFBO_OFF_STATUS 8'h10
`define PFBO_OFF_PRE0 8'h14
`define PFBO_OFF_PRE1 8'h18
`define PFBO_OFF_PRE2 8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PFBO_CTRL_GO 0
`define PFBO_CTRL_OP_LO 1
`define PFBO_CTRL_OP_HI 2
`define PFBO_CTRL_FAST 3
`define PFBO_CTRL_BYTE 4
`define PFBO_ST_BUSY 0
`define PFBO_ST_DONE 1
`define PFBO_ST_RDY 2
`define PFBO_ST_ABORT 3
`define PFBO_ST_SEC_LO 4
`define PFBO_ST_SEC_HI 8
`define PFBO_PRE_DATA_LO 24
`define PFBO_PRE_DATA_HI 31

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PFBO_RST_ADDR 20'h00000
`define PFBO_RST_DATA 16'h0000
`define PFBO_RST_PRE 28'h0000000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PFBO_CLK_NS 4
`define PFBO_T_SETUP_NS 10
`define PFBO_T_WP_NS 35
`define PFBO_T_HOLD_NS 20
`define PFBO_ADDRESS_ACCESS_TIME_NS 70
`define PFBO_T_RP_NS 500
`define PFBO_T_RH_NS 50
`define PFBO_CYC(ns) (((ns) + `PFBO_CLK_NS - 1) / `PFBO_CLK_NS)
`define PFBO_SETUP_CYC `PFBO_CYC(`PFBO_T_SETUP_NS)
`define PFBO_WP_CYC `PFBO_CYC(`PFBO_T_WP_NS)
`define PFBO_HOLD_CYC `PFBO_CYC(`PFBO_T_HOLD_NS)
`define PFBO_ACC_CYC `PFBO_CYC(`PFBO_ADDRESS_ACCESS_TIME_NS)
`define PFBO_RP_CYC `PFBO_CYC(`PFBO_T_RP_NS)
`define PFBO_RH_CYC `PFBO_CYC(`PFBO_T_RH_NS)

`endif

// ### pfbo_pkg.sv
// Types shared by the flash host files.
package pfbo_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_SETUP,
        S_STROBE,
        S_HOLD,
        S_RSTLOW,
        S_RSTWAIT
    } pfbo_state_e;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_PROG,
        OP_RESET
    } pfbo_op_e;

    typedef struct packed {
        pfbo_state_e state;
        logic [15:0] cnt;
        logic [1:0] step;
        pfbo_op_e op;
        logic fast;
        logic byteMode;
        logic [19:0] addr;
        logic [15:0] wdata;
        logic [27:0] pre0;
        logic [27:0] pre1;
        logic [27:0] pre2;
        logic [15:0] rdata;
        logic done;
        logic aborted;
        logic rbSample;
        logic [18:0] pinAddr;
        logic [15:0] dqOut;
        logic [15:0] dqOe;
        logic csN;
        logic oeN;
        logic weN;
        logic rstN;
        logic byteN;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pfbo_host_s;

    typedef struct packed {
        logic [4:0] sector;
    } pfbo_sector_s;

endpackage : pfbo_pkg

// ### pfbo_sector_map.sv
// Top-boot sector number of a device address.
`timescale 1ns/10ps
`default_nettype none
module pfbo_sector_map
    import pfbo_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic byteMode,
    input wire logic [19:0] devAddr,
    output logic [4:0] sector
);

    pfbo_sector_s st_ff;
    pfbo_sector_s nxt_st;
    logic [19:0] byteAddr;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        byteAddr = byteMode ? devAddr : {devAddr[18:0], 1'b0};
        // Only bits 19..13 of byteAddr take part: A18..A12 of a word address, A19..A13 of a byte address.
        if (byteAddr[19:16] != 4'hf) begin
            nxt_st.sector = {1'b0, byteAddr[19:16]};
        end else if (!byteAddr[15]) begin
            nxt_st.sector = 5'h0f;
        end else if (byteAddr[14:13] == 2'h0) begin
            nxt_st.sector = 5'h10;
        end else if (byteAddr[14:13] == 2'h1) begin
            nxt_st.sector = 5'h11;
        end else begin
            nxt_st.sector = 5'h12;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sector = st_ff.sector;

endmodule : pfbo_sector_map
`default_nettype wire

// ### pfbo_host.sv
// Flash bus host: APB registers in, asynchronous flash pins out.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pfbo_defines.svh"
module pfbo_host
    import pfbo_pkg::*;
#(
    parameter int unsigned SETUP_CYC = `PFBO_SETUP_CYC,
    parameter int unsigned WP_CYC = `PFBO_WP_CYC,
    parameter int unsigned HOLD_CYC = `PFBO_HOLD_CYC,
    parameter int unsigned ACC_CYC = `PFBO_ACC_CYC,
    parameter int unsigned RP_CYC = `PFBO_RP_CYC,
    parameter int unsigned RH_CYC = `PFBO_RH_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [18:0] flashAddr,
    input wire logic [15:0] dqIn,
    output logic [15:0] dqOut,
    output logic [15:0] dqOe,
    output logic chipSelectN,
    output logic outputEnableN,
    output logic writeStrobeN,
    output logic resetN,
    output logic widthSelectN,
    input wire logic readyBusyN
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == `PFBO_OFF_CTRL) || (a == `PFBO_OFF_ADDR) ||
                   (a == `PFBO_OFF_WDATA) || (a == `PFBO_OFF_RDATA) ||
                   (a == `PFBO_OFF_STATUS) || (a == `PFBO_OFF_PRE0) ||
                   (a == `PFBO_OFF_PRE1) || (a == `PFBO_OFF_PRE2);
    endfunction : isMapped

    function automatic logic [1:0] lastStep(input pfbo_op_e op,
                                            input logic fast);
        if (op == OP_PROG) begin
            lastStep = fast ? 2'd1 : 2'd3;
        end else begin
            lastStep = 2'd0;
        end
    endfunction : lastStep

    function automatic logic [1:0] srcSel(input pfbo_op_e op,
                                          input logic fast,
                                          input logic [1:0] step);
        if (op != OP_PROG) begin
            srcSel = 2'd3;
        end else if (fast) begin
            srcSel = step + 2'd2;
        end else begin
            srcSel = step;
        end
    endfunction : srcSel

    function automatic logic cntEnd(input logic [15:0] cnt,
                                    input int unsigned n);
        cntEnd = (cnt == 16'(n - 1));
    endfunction : cntEnd

    pfbo_host_s st_ff;
    pfbo_host_s nxt_st;
    logic [4:0] sectorNum;
    logic [31:0] readMux;
    logic wrAcc;
    logic go;
    logic [19:0] cycAddr;
    logic [15:0] cycData;
    logic [27:0] cycPre;
    logic [1:0] sel;

    pfbo_sector_map u_sector (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .byteMode(st_ff.byteMode),
        .devAddr(st_ff.addr),
        .sector(sectorNum)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        readMux = 32'h00000000;
        case (paddr)
            `PFBO_OFF_CTRL: begin
                readMux = {27'h0000000, st_ff.byteMode, st_ff.fast,
                           st_ff.op, 1'b0};
            end
            `PFBO_OFF_ADDR: readMux = {12'h000, st_ff.addr};
            `PFBO_OFF_WDATA: readMux = {16'h0000, st_ff.wdata};
            `PFBO_OFF_RDATA: readMux = {16'h0000, st_ff.rdata};
            `PFBO_OFF_STATUS: begin
                readMux = {23'h000000, sectorNum, st_ff.aborted,
                           st_ff.rbSample, st_ff.done,
                           (st_ff.state != S_IDLE)};
            end
            `PFBO_OFF_PRE0: begin
                readMux = {st_ff.pre0[27:20], 4'h0, st_ff.pre0[19:0]};
            end
            `PFBO_OFF_PRE1: begin
                readMux = {st_ff.pre1[27:20], 4'h0, st_ff.pre1[19:0]};
            end
            `PFBO_OFF_PRE2: begin
                readMux = {st_ff.pre2[27:20], 4'h0, st_ff.pre2[19:0]};
            end
            default: readMux = 32'h00000000;
        endcase

        // One wait state, then the answer for one cycle.
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        if (psel && penable && !st_ff.pready) begin
            nxt_st.pready = 1'b1;
            nxt_st.pslverr = !isMapped(paddr);
            nxt_st.prdata = readMux;
        end
        wrAcc = psel && penable && st_ff.pready && pwrite;
        go = 1'b0;
        nxt_st.rbSample = readyBusyN;

        if (wrAcc) begin
            case (paddr)
                `PFBO_OFF_CTRL: begin
                    if (st_ff.state == S_IDLE) begin
                        nxt_st.op = pfbo_op_e'(
                            pwdata[`PFBO_CTRL_OP_HI:`PFBO_CTRL_OP_LO]);
                        nxt_st.fast = pwdata[`PFBO_CTRL_FAST];
                        nxt_st.byteMode = pwdata[`PFBO_CTRL_BYTE];
                        go = pwdata[`PFBO_CTRL_GO];
                    end
                end
                `PFBO_OFF_ADDR: nxt_st.addr = pwdata[19:0];
                `PFBO_OFF_WDATA: nxt_st.wdata = pwdata[15:0];
                `PFBO_OFF_STATUS: begin
                    if (pwdata[`PFBO_ST_DONE]) begin
                        nxt_st.done = 1'b0;
                    end
                    if (pwdata[`PFBO_ST_ABORT]) begin
                        nxt_st.aborted = 1'b0;
                    end
                end
                `PFBO_OFF_PRE0: begin
                    nxt_st.pre0 = {pwdata[31:24], pwdata[19:0]};
                end
                `PFBO_OFF_PRE1: begin
                    nxt_st.pre1 = {pwdata[31:24], pwdata[19:0]};
                end
                `PFBO_OFF_PRE2: begin
                    nxt_st.pre2 = {pwdata[31:24], pwdata[19:0]};
                end
                default: ;
            endcase
        end

        // Address and data of the current bus cycle.
        sel = srcSel(st_ff.op, st_ff.fast, st_ff.step);
        case (sel)
            2'd0: cycPre = st_ff.pre0;
            2'd1: cycPre = st_ff.pre1;
            2'd2: cycPre = st_ff.pre2;
            default: cycPre = {st_ff.wdata[7:0], st_ff.addr};
        endcase
        cycAddr = cycPre[19:0];
        cycData = (sel == 2'd3) ? st_ff.wdata : {8'h00, cycPre[27:20]};
        nxt_st.byteN = !st_ff.byteMode;

        case (st_ff.state)
            S_IDLE: begin
                nxt_st.csN = 1'b1;
                nxt_st.oeN = 1'b1;
                nxt_st.weN = 1'b1;
                nxt_st.dqOe = 16'h0000;
                nxt_st.cnt = 16'h0000;
                nxt_st.step = 2'd0;
                if (go && nxt_st.op == OP_RESET) begin
                    nxt_st.state = S_RSTLOW;
                    nxt_st.rstN = 1'b0;
                    if (!st_ff.rbSample) begin
                        nxt_st.aborted = 1'b1;
                    end
                end else if (go && st_ff.rstN) begin
                    nxt_st.state = S_SETUP;
                end
            end
            S_SETUP: begin
                nxt_st.csN = 1'b0;
                nxt_st.oeN = 1'b1;
                nxt_st.weN = 1'b1;
                if (st_ff.byteMode) begin
                    nxt_st.pinAddr = cycAddr[19:1];
                    nxt_st.dqOut = {cycAddr[0], 7'h00, cycData[7:0]};
                    nxt_st.dqOe = {1'b1, 7'h00,
                                   {8{st_ff.op != OP_READ}}};
                end else begin
                    nxt_st.pinAddr = cycAddr[18:0];
                    nxt_st.dqOut = cycData;
                    nxt_st.dqOe = {16{st_ff.op != OP_READ}};
                end
                nxt_st.cnt = st_ff.cnt + 16'h0001;
                if (cntEnd(st_ff.cnt, SETUP_CYC)) begin
                    nxt_st.cnt = 16'h0000;
                    nxt_st.state = S_STROBE;
                end
            end
            S_STROBE: begin
                if (st_ff.op == OP_READ) begin
                    nxt_st.oeN = 1'b0;
                    nxt_st.weN = 1'b1;
                end else begin
                    nxt_st.weN = 1'b0;
                    nxt_st.oeN = 1'b1;
                end
                nxt_st.cnt = st_ff.cnt + 16'h0001;
                if (cntEnd(st_ff.cnt,
                           (st_ff.op == OP_READ) ? ACC_CYC : WP_CYC)) begin
                    nxt_st.cnt = 16'h0000;
                    nxt_st.state = S_HOLD;
                    if (st_ff.op == OP_READ) begin
                        nxt_st.rdata = st_ff.byteMode ?
                                       {8'h00, dqIn[7:0]} : dqIn;
                    end
                end
            end
            S_HOLD: begin
                nxt_st.oeN = 1'b1;
                nxt_st.weN = 1'b1;
                nxt_st.cnt = st_ff.cnt + 16'h0001;
                if (cntEnd(st_ff.cnt, HOLD_CYC)) begin
                    nxt_st.cnt = 16'h0000;
                    nxt_st.csN = 1'b1;
                    nxt_st.dqOe = 16'h0000;
                    if (st_ff.step == lastStep(st_ff.op, st_ff.fast)) begin
                        nxt_st.state = S_IDLE;
                        nxt_st.done = 1'b1;
                    end else begin
                        nxt_st.step = st_ff.step + 2'd1;
                        nxt_st.state = S_SETUP;
                    end
                end
            end
            S_RSTLOW: begin
                nxt_st.csN = 1'b1;
                nxt_st.rstN = 1'b0;
                nxt_st.cnt = st_ff.cnt + 16'h0001;
                if (cntEnd(st_ff.cnt, RP_CYC)) begin
                    nxt_st.cnt = 16'h0000;
                    nxt_st.rstN = 1'b1;
                    nxt_st.state = S_RSTWAIT;
                end
            end
            S_RSTWAIT: begin
                // Wait for busy to clear, then the recovery time.
                if (!st_ff.rbSample) begin
                    nxt_st.cnt = 16'h0000;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 16'h0001;
                    if (cntEnd(st_ff.cnt, RH_CYC)) begin
                        nxt_st.cnt = 16'h0000;
                        nxt_st.state = S_IDLE;
                        nxt_st.done = 1'b1;
                    end
                end
            end
            default: nxt_st.state = S_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= '{state: S_RSTLOW, cnt: 16'h0000, step: 2'd0,
                       op: OP_READ, fast: 1'b0, byteMode: 1'b0,
                       addr: `PFBO_RST_ADDR, wdata: `PFBO_RST_DATA,
                       pre0: `PFBO_RST_PRE, pre1: `PFBO_RST_PRE,
                       pre2: `PFBO_RST_PRE, rdata: `PFBO_RST_DATA,
                       done: 1'b0, aborted: 1'b0, rbSample: 1'b1,
                       pinAddr: 19'h00000, dqOut: 16'h0000,
                       dqOe: 16'h0000, csN: 1'b1, oeN: 1'b1, weN: 1'b1,
                       rstN: 1'b0, byteN: 1'b1, pready: 1'b0,
                       pslverr: 1'b0, prdata: 32'h00000000};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign flashAddr = st_ff.pinAddr;
    assign dqOut = st_ff.dqOut;
    assign dqOe = st_ff.dqOe;
    assign chipSelectN = st_ff.csN;
    assign outputEnableN = st_ff.oeN;
    assign writeStrobeN = st_ff.weN;
    assign resetN = st_ff.rstN;
    assign widthSelectN = st_ff.byteN;

endmodule : pfbo_host
`default_nettype wire

// ### pfbo_flash_model.sv
// Behavioural flash device on the host's pins.
`timescale 1ns/10ps
`default_nettype none
module pfbo_flash_model #(
    parameter int PROG_CYC = 80,
    parameter int READY_CYC = 20,
    parameter logic [7:0] ID_CODE = 8'h3c // Arbitrary value.
) (
    input wire logic mclk,
    input wire logic [18:0] flashAddr,
    input wire logic [15:0] dqOut,
    input wire logic [15:0] dqOe,
    input wire logic chipSelectN,
    input wire logic outputEnableN,
    input wire logic writeStrobeN,
    input wire logic resetN,
    input wire logic widthSelectN,
    output logic [15:0] dqIn,
    output logic readyBusyN
);
    // ----------------------------------------
    // Command state and array
    // ----------------------------------------
    logic [15:0] mem [16];
    logic [15:0] rd, d, pData;
    logic [15:0] flt = 16'h0000;
    logic [3:0] pAddr;
    logic weDly = 1'b1;
    logic fast = 1'b0;
    logic drv;
    int st = 0;
    int busy = 0;
    int nWr = 0;
    initial foreach (mem[i]) mem[i] = 16'hffff;
    always @(posedge mclk) begin
        d = widthSelectN ? dqOut : {8'h00, dqOut[7:0]};
        weDly <= writeStrobeN;
        flt <= ~dqIn;
        if (!resetN) begin
            st <= 0;
            fast <= 1'b0;
            if (busy > 0) busy <= READY_CYC;
        end else if (busy > 0) begin
            busy <= busy - 1;
            if (busy == 1 && st == 8) mem[pAddr] <= pData;
            if (busy == 1 && st == 9)
                foreach (mem[i]) mem[i] <= 16'hffff;
            if (busy == 1) st <= 0;
        end else if (writeStrobeN && !weDly && !chipSelectN) begin
            nWr <= nWr + 1;
            case (st)
                0: st <= d[7:0] == 8'haa ? 1 :
                    (fast && d[7:0] == 8'ha0) ? 3 : 0;
                1: st <= d[7:0] == 8'h55 ? 2 : 0;
                2: begin
                    st <= d[7:0] == 8'ha0 ? 3 : d[7:0] == 8'h90 ? 7 :
                        d[7:0] == 8'h80 ? 4 : 0;
                    fast <= fast || d[7:0] == 8'h20;
                end
                3: begin
                    pAddr <= flashAddr[3:0];
                    pData <= d;
                    busy <= PROG_CYC;
                    st <= 8;
                end
                4: st <= d[7:0] == 8'haa ? 5 : 0;
                5: st <= d[7:0] == 8'h55 ? 6 : 0;
                6: begin
                    busy <= PROG_CYC;
                    st <= 9;
                end
                default: st <= d[7:0] == 8'hf0 ? 0 : st;
            endcase
        end
    end
    assign drv = !chipSelectN && !outputEnableN && resetN;
    assign readyBusyN = busy == 0;
    always_comb begin
        if (busy > 0) rd = {8'h00, ~pData[7], 7'h00};
        else if (st == 7) rd = {8'h00, ID_CODE};
        else rd = mem[flashAddr[3:0]];
        if (!widthSelectN) rd = {8'h00, dqOut[15] ? rd[15:8] : rd[7:0]};
        for (int i = 0; i < 16; i++)
            dqIn[i] = dqOe[i] ? dqOut[i] :
                (drv && (widthSelectN || i < 8)) ? rd[i] : flt[i];
    end
endmodule : pfbo_flash_model
`default_nettype wire

// ### pfbo_host_properties.sv
// Assertions on the flash host's bus and pin timing.
`timescale 1ns/10ps
`default_nettype none
module pfbo_host_properties #(
    parameter int unsigned SETUP_CYC = 3,
    parameter int unsigned WP_CYC = 9,
    parameter int unsigned RP_CYC = 125
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [15:0] dqOe,
    input wire logic chipSelectN,
    input wire logic outputEnableN,
    input wire logic writeStrobeN,
    input wire logic resetN,
    input wire logic widthSelectN
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic [15:0] lowCnt_ff;
    always_ff @(posedge mclk)
        lowCnt_ff <= (sys_rst || resetN) ? 16'h0000 : lowCnt_ff + 16'h0001;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_access_start;
        psel && $rose(penable);
    endsequence
    sequence s_strobe_end;
        $rose(writeStrobeN);
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_apb_one_wait: assert property (s_access_start |=> pready)
        else $error("pready not one cycle after access");
    a_write_levels: assert property (
        !writeStrobeN |-> !chipSelectN && outputEnableN)
        else $error("write strobe with wrong select levels");
    a_read_levels: assert property (
        !outputEnableN |-> !chipSelectN && writeStrobeN)
        else $error("read enable with wrong select levels");
    a_select_after_rst: assert property (
        $fell(chipSelectN) |-> resetN && $past(resetN))
        else $error("select lowered while reset low");
    a_reset_width: assert property (
        $rose(resetN) |-> lowCnt_ff >= RP_CYC)
        else $error("reset pulse too short");
    a_strobe_width: assert property (s_strobe_end |->
        !$past(writeStrobeN, WP_CYC) && $past(writeStrobeN, WP_CYC + 1))
        else $error("write strobe width wrong");
    a_setup_cs: assert property (
        $fell(writeStrobeN) |-> !$past(chipSelectN, SETUP_CYC))
        else $error("select setup before strobe short");
    a_byte_float: assert property (
        !widthSelectN |-> dqOe[14:8] == 7'h00)
        else $error("upper data lines driven in byte mode");
    a_read_release: assert property (
        !outputEnableN |-> dqOe[14:0] == 15'h0000)
        else $error("host drives data during read");
endmodule : pfbo_host_properties
bind pfbo_host pfbo_host_properties #(.SETUP_CYC(SETUP_CYC),
    .WP_CYC(WP_CYC), .RP_CYC(RP_CYC)) chk_u (.mclk(mclk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
    .dqOe(dqOe), .chipSelectN(chipSelectN),
    .outputEnableN(outputEnableN), .writeStrobeN(writeStrobeN),
    .resetN(resetN), .widthSelectN(widthSelectN));
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the flash host and the device model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, lastErr, csN, oeN, weN, rstN, byteN, rdyN;
    logic [18:0] fAddr;
    logic [15:0] dqIn, dqOut, dqOe;
    int fails = 0;
    int numChecks = 0;
    int base;
    pfbo_host #(.SETUP_CYC(2), .WP_CYC(2), .ACC_CYC(3),
        .RP_CYC(4), .RH_CYC(2)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flashAddr(fAddr), .dqIn(dqIn), .dqOut(dqOut),
        .dqOe(dqOe), .chipSelectN(csN), .outputEnableN(oeN),
        .writeStrobeN(weN), .resetN(rstN), .widthSelectN(byteN),
        .readyBusyN(rdyN));
    pfbo_flash_model dev_u (.mclk(mclk), .flashAddr(fAddr), .dqOut(dqOut),
        .dqOe(dqOe), .chipSelectN(csN), .outputEnableN(oeN),
        .writeStrobeN(weN), .resetN(rstN), .widthSelectN(byteN),
        .dqIn(dqIn), .readyBusyN(rdyN));
    initial forever #2 mclk = ~mclk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic expire();
        fails++;
        summarize();
    endtask : expire
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) expire();
        r = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic waitBit(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h10, 32'h0);
            n++;
        end while (r[b] !== 1'b1 && n < 200);
        if (r[b] !== 1'b1) expire();
    endtask : waitBit
    task automatic cyc(input logic [19:0] a, input logic [15:0] d,
            input logic [31:0] c);
        apb(1'b1, 8'h04, {12'h000, a});
        apb(1'b1, 8'h08, {16'h0000, d});
        apb(1'b1, 8'h10, 32'h0000000a);
        apb(1'b1, 8'h00, c);
        waitBit(1);
    endtask : cyc
    task automatic rdf(input logic [19:0] a, input logic [31:0] c);
        cyc(a, 16'h0000, c);
        apb(1'b0, 8'h0c, 32'h0);
    endtask : rdf
    task automatic unl(input logic [15:0] c);
        cyc(20'h00555, 16'h00aa, 32'h3);
        cyc(20'h002aa, 16'h0055, 32'h3);
        cyc(20'h00555, c, 32'h3);
    endtask : unl
    task automatic t_init();
        apb(1'b0, 8'h10, 32'h0);
        `CHK("status", 32'h00000006, r)
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("pre2", 32'h0, r)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("rd err", 1'b1, lastErr)
        apb(1'b1, 8'h24, 32'hffffffff);
        `CHK("wr err", 1'b1, lastErr)
        unl(16'h0090);
        rdf(20'h00000, 32'h1);
        `CHK("id", 16'h003c, r[15:0])
        cyc(20'h00000, 16'h00f0, 32'h3);
        rdf(20'h00000, 32'h1);
        `CHK("array", 16'hffff, r[15:0])
        $display("init, map and identify done");
    endtask : t_init
    task automatic t_prog();
        apb(1'b1, 8'h14, 32'haa000555);
        apb(1'b1, 8'h18, 32'h550002aa);
        apb(1'b1, 8'h1c, 32'ha0000555);
        base = dev_u.nWr;
        cyc(20'h00123, 16'h1234, 32'h5);
        `CHK("writes", 4, dev_u.nWr - base)
        rdf(20'h00123, 32'h1);
        `CHK("poll", 16'h0080, r[15:0])
        waitBit(2);
        rdf(20'h00123, 32'h1);
        `CHK("data", 16'h1234, r[15:0])
        unl(16'h0020);
        base = dev_u.nWr;
        cyc(20'h7e010, 16'h5678, 32'hd);
        `CHK("fast", 2, dev_u.nWr - base)
        waitBit(2);
        rdf(20'h7e010, 32'h1);
        `CHK("fdata", 16'h5678, r[15:0])
        $display("program standard and fast done");
    endtask : t_prog
    task automatic t_sector();
        logic [19:0] a [8] = '{20'h00000, 20'h08000, 20'h70000, 20'h77fff,
            20'h78000, 20'h7c000, 20'h7d000, 20'h7efff};
        logic [4:0] s [8] = '{5'h00, 5'h01, 5'h0e, 5'h0e, 5'h0f, 5'h10,
            5'h11, 5'h12};
        foreach (a[i]) begin
            apb(1'b1, 8'h04, {12'h000, a[i]});
            apb(1'b0, 8'h10, 32'h0);
            `CHK("sector", s[i], r[8:4])
        end
        rdf(20'h00247, 32'h11);
        `CHK("byte hi", 8'h12, r[7:0])
        rdf(20'h00246, 32'h11);
        `CHK("byte lo", 8'h34, r[7:0])
        apb(1'b1, 8'h04, 32'h000fa000);
        apb(1'b0, 8'h10, 32'h0);
        `CHK("byte sector", 5'h11, r[8:4])
        $display("sector map and byte mode done");
    endtask : t_sector
    task automatic t_reset();
        cyc(20'h00209, 16'h0000, 32'h5);
        cyc(20'h00209, 16'h0000, 32'h7);
        apb(1'b0, 8'h10, 32'h0);
        `CHK("aborted", 1'b1, r[3])
        waitBit(2);
        rdf(20'h00209, 32'h1);
        `CHK("after abort", 16'hffff, r[15:0])
        cyc(20'h00209, 16'h0000, 32'h5);
        waitBit(2);
        rdf(20'h00209, 32'h1);
        `CHK("reissued", 16'h0000, r[15:0])
        unl(16'h0080);
        unl(16'h0030);
        waitBit(2);
        rdf(20'h00209, 32'h1);
        `CHK("erased", 16'hffff, r[15:0])
        $display("reset abort and erase done");
    endtask : t_reset
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        waitBit(1);
        t_init();
        t_prog();
        t_sector();
        t_reset();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
